// ==== hdl/power_mode_pkg.sv ====
package power_mode_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_SYSTEM_CLOCK_SOURCE = 8'h8F;
    localparam logic [7:0] IDX_WAKE_MASK = 8'h9F;
    localparam logic [7:0] IDX_POWER_CONTROL = 8'hA0;
    localparam logic [7:0] IDX_WDOG_CTRL = 8'hA1;
    localparam logic [7:0] IDX_POWER_STATUS = 8'hA2;
    localparam logic [11:0] ADDR_SYSTEM_CLOCK_SOURCE = {2'h0, IDX_SYSTEM_CLOCK_SOURCE, 2'h0};
    localparam logic [11:0] ADDR_WAKE_MASK = {2'h0, IDX_WAKE_MASK, 2'h0};
    localparam logic [11:0] ADDR_POWER_CONTROL = {2'h0, IDX_POWER_CONTROL, 2'h0};
    localparam logic [11:0] ADDR_WDOG_CTRL = {2'h0, IDX_WDOG_CTRL, 2'h0};
    localparam logic [11:0] ADDR_POWER_STATUS = {2'h0, IDX_POWER_STATUS, 2'h0};

    // reset values
    localparam logic [7:0] RST_WAKE_MASK = 8'hFF;
    localparam logic [7:0] RST_SYSTEM_CLOCK_SOURCE = 8'h0C;

    // system_clock_source_reg fields
    localparam int CLKSRC_LSB = 0;
    localparam int SETTLE_LSB = 2;

    // power_control_reg fields
    localparam int PWR_IDLE_BIT = 0;
    localparam int PWR_STOP_BIT = 1;
    localparam int PWR_SLEEP_BIT = 2;

    // watchdog control fields
    localparam int WD_EN_BIT = 0;
    localparam int WD_RSTMODE_BIT = 1;
    localparam int WD_RESTART_BIT = 2;
    localparam int WD_FLAG_BIT = 3;
    localparam logic [29:0] WDOG_LIMIT_DEFAULT = 30'h3FFFFFFF;

    // settle delays in slow oscillator cycles
    localparam logic [8:0] SETTLE_CYC_0 = 9'h008;
    localparam logic [8:0] SETTLE_CYC_1 = 9'h010;
    localparam logic [8:0] SETTLE_CYC_2 = 9'h040;
    localparam logic [8:0] SETTLE_CYC_3 = 9'h100;

    // system clock multiplexer codes
    localparam logic [1:0] MUX_FAST_DIV = 2'h0;
    localparam logic [1:0] MUX_SLOW = 2'h1;
    localparam logic [1:0] MUX_EXTERNAL = 2'h2;

    localparam int EXT_LINES = 8;
    localparam int CLOCKLESS_SRC = 3;
    localparam int WAKE_SRC = EXT_LINES + CLOCKLESS_SRC;

    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_STOP_ENTRY = 3'h1,
        ST_SLEEP = 3'h3,
        ST_SETTLE = 3'h2,
        ST_STOP = 3'h5,
        ST_IDLE = 3'h4
    } power_state_t;

endpackage : power_mode_pkg

// ==== hdl/power_mode_wakeup_control.sv ====
`timescale 1ns/10ps
// What this block does
// - eight mask bits each allow one external or pin-change line to wake; reset all ones
// - wake detection uses the source edge even for level-triggered interrupts
// - wake works without interrupt enable; then CPU resumes at next instruction
// - wake from STOP or SLEEP restarts fast oscillator and resumes system clock
// - only pins, touch key, LIN wake and slow timer may wake from STOP or SLEEP
// - setting idle stops CPU clock; other peripherals keep their clock
// - in IDLE integrated peripherals are blocked and no instructions run
// - IDLE ends on reset or an enabled external interrupt line
// - on IDLE exit the CPU vectors at once to the waking source
// - hardware clears the idle bit when returning from IDLE
// - setting stop gates all clocks and disables the fast oscillator
// - oscillator shutdown is aligned to its last clock edge
// - STOP exit clears stop bit, restarts oscillator, keeps prior clock settings
// - a line ends STOP only when its mask bit is set; vectoring needs enable
// - after a STOP wake service the CPU retries the STOP instruction
// - SLEEP turns off main regulator; state and SRAM kept
// - SLEEP exits like STOP, re-enables regulator, waits settle delay
// - settle field picks 8, 16, 64 or 256 slow cycles, also after reset
// - system clock from divided fast oscillator, slow or external; divided after reset
// - source codes 00 and 10 divided fast, 01 slow, 11 external
// - 30-bit watchdog runs on CPU clock, halts in IDLE and STOP, irq or reset
module power_mode_wakeup_control
    import power_mode_pkg::*;
#(
    parameter logic [29:0] WDOG_LIMIT = WDOG_LIMIT_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [EXT_LINES-1:0] ext_wake_pins,
    input wire logic touch_key_unit_wake,
    input wire logic lin_wake,
    input wire logic slow_timer_wake,
    input wire logic slow_osc,
    input wire logic fast_internal_osc,
    input wire logic [EXT_LINES-1:0] irq_lines,
    input wire logic [EXT_LINES-1:0] irq_enable,
    input wire logic cpu_instr_done,
    output logic cpu_clock_en,
    output logic periph_clock_en,
    output logic integrated_block,
    output logic osc_enable,
    output logic main_regulator_en,
    output logic [1:0] system_clock_mux_sel,
    output logic wake_resume,
    output logic [EXT_LINES-1:0] wake_vector,
    output logic resume_retry,
    output logic wdog_irq,
    output logic wdog_reset
);

    function automatic logic [8:0] settle_cycles(input logic [1:0] code);
        case (code)
            2'h0: settle_cycles = SETTLE_CYC_0;
            2'h1: settle_cycles = SETTLE_CYC_1;
            2'h2: settle_cycles = SETTLE_CYC_2;
            default: settle_cycles = SETTLE_CYC_3;
        endcase
    endfunction : settle_cycles

    function automatic logic [1:0] clock_mux(input logic [1:0] code);
        case (code)
            2'h1: clock_mux = MUX_SLOW;
            2'h3: clock_mux = MUX_EXTERNAL;
            default: clock_mux = MUX_FAST_DIV;
        endcase
    endfunction : clock_mux

    power_state_t state;
    power_state_t next_state;
    logic [7:0] wake_mask;
    logic [7:0] system_clock_source;
    logic [2:0] power_ctrl;
    logic wdog_en;
    logic wdog_rstmode;
    logic wdog_flag;
    logic [29:0] wdog_count;
    logic [8:0] settle_count;
    logic [WAKE_SRC-1:0] wake_latch;
    logic [WAKE_SRC-1:0] wake_s1;
    logic [WAKE_SRC-1:0] wake_s2;
    logic [WAKE_SRC-1:0] wake_s3;
    logic [2:0] slow_sync;
    logic [2:0] fast_sync;

    // bus decode
    wire bus_setup = psel && !penable;
    wire bus_write = psel && penable && pwrite;
    wire hit_source = (paddr == ADDR_SYSTEM_CLOCK_SOURCE);
    wire hit_mask = (paddr == ADDR_WAKE_MASK);
    wire hit_power = (paddr == ADDR_POWER_CONTROL);
    wire hit_wdog = (paddr == ADDR_WDOG_CTRL);
    wire hit_status = (paddr == ADDR_POWER_STATUS);
    wire hit_any = hit_source || hit_mask || hit_power || hit_wdog || hit_status;
    wire wr_source = bus_write && hit_source;
    wire wr_mask = bus_write && hit_mask;
    wire wr_power = bus_write && hit_power;
    wire wr_wdog = bus_write && hit_wdog;
    wire [31:0] read_word = hit_source ? {24'h0, system_clock_source} :
                            hit_mask ? {24'h0, wake_mask} :
                            hit_power ? {29'h0, power_ctrl} :
                            hit_wdog ? {28'h0, wdog_flag, 1'b0, wdog_rstmode, wdog_en} :
                            hit_status ? {18'h0, wake_latch, state} : 32'h0;

    assign pready = 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (bus_setup) begin
            prdata <= pwrite ? 32'h0 : read_word;
            pslverr <= !hit_any;
        end
    end

    // synchronisers for asynchronous pins
    wire [WAKE_SRC-1:0] wake_pins = {slow_timer_wake, lin_wake, touch_key_unit_wake,
                                     ext_wake_pins};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_s1 <= '0;
            wake_s2 <= '0;
            wake_s3 <= '0;
            slow_sync <= 3'h0;
            fast_sync <= 3'h0;
        end else begin
            wake_s1 <= wake_pins;
            wake_s2 <= wake_s1;
            wake_s3 <= wake_s2;
            slow_sync <= {slow_sync[1:0], slow_osc};
            fast_sync <= {fast_sync[1:0], fast_internal_osc};
        end
    end

    wire slow_tick = slow_sync[1] && !slow_sync[2];
    wire fast_last_edge = !fast_sync[1] && fast_sync[2];
    wire [WAKE_SRC-1:0] wake_rise = wake_s2 & ~wake_s3;
    // clocked peripherals have no path here; clockless sources always allowed
    wire [WAKE_SRC-1:0] wake_allow = {{CLOCKLESS_SRC{1'b1}}, wake_mask};
    wire [WAKE_SRC-1:0] wake_hit = wake_rise & wake_allow;
    wire clock_parked = (state == ST_STOP_ENTRY) || (state == ST_STOP) ||
                        (state == ST_SLEEP) || (state == ST_SETTLE);
    wire wake_any = |wake_latch;
    wire [EXT_LINES-1:0] ext_woken = wake_latch[EXT_LINES-1:0];
    wire [EXT_LINES-1:0] stop_vector = ext_woken & irq_enable;
    wire [EXT_LINES-1:0] idle_vector = irq_lines & irq_enable;
    wire idle_exit = |idle_vector;
    wire [8:0] settle_limit = settle_cycles(system_clock_source[SETTLE_LSB+:2]);
    wire settle_done = slow_tick && (settle_count == settle_limit - 9'h001);
    wire stop_req = power_ctrl[PWR_STOP_BIT] || power_ctrl[PWR_SLEEP_BIT];

    // next power state
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (stop_req && cpu_instr_done) begin
                    next_state = ST_STOP_ENTRY;
                end else if (power_ctrl[PWR_IDLE_BIT] && cpu_instr_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (idle_exit) begin
                    next_state = ST_RUN;
                end
            end
            ST_STOP_ENTRY: begin
                if (fast_last_edge) begin
                    next_state = power_ctrl[PWR_SLEEP_BIT] ? ST_SLEEP : ST_STOP;
                end
            end
            ST_STOP: begin
                if (wake_any) begin
                    next_state = ST_RUN;
                end
            end
            ST_SLEEP: begin
                if (wake_any) begin
                    next_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (settle_done) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    wire leave_idle = (state == ST_IDLE) && (next_state == ST_RUN);
    wire leave_park = clock_parked && (next_state == ST_RUN);

    // state starts in settle so the reset delay is honoured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_SETTLE;
            settle_count <= 9'h000;
        end else begin
            state <= next_state;
            if (state != ST_SETTLE) begin
                settle_count <= 9'h000;
            end else if (slow_tick) begin
                settle_count <= settle_count + 9'h001;
            end
        end
    end

    // wake latch, the clear on clock return wins over a new set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_latch <= '0;
        end else if (clock_parked) begin
            wake_latch <= wake_latch | wake_hit;
        end else begin
            wake_latch <= '0;
        end
    end

    // registers written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_mask <= RST_WAKE_MASK;
            system_clock_source <= RST_SYSTEM_CLOCK_SOURCE;
        end else begin
            if (wr_mask) begin
                wake_mask <= pwdata[7:0];
            end
            if (wr_source) begin
                system_clock_source <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_ctrl <= 3'h0;
        end else if (leave_idle) begin
            power_ctrl[PWR_IDLE_BIT] <= 1'b0;
        end else if (leave_park) begin
            power_ctrl <= 3'h0;
        end else if (wr_power) begin
            power_ctrl <= power_ctrl | pwdata[2:0];
        end
    end

    // resume information for the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_resume <= 1'b0;
            wake_vector <= '0;
            resume_retry <= 1'b0;
        end else begin
            wake_resume <= leave_idle || leave_park;
            if (leave_idle) begin
                wake_vector <= idle_vector;
                resume_retry <= 1'b0;
            end else if (leave_park) begin
                wake_vector <= stop_vector;
                resume_retry <= |stop_vector;
            end
        end
    end

    // clock and power gating; the source setting is never touched by sequencing
    assign cpu_clock_en = (state == ST_RUN);
    assign periph_clock_en = (state == ST_RUN) || (state == ST_IDLE);
    assign integrated_block = (state != ST_RUN);
    assign osc_enable = (state != ST_STOP) && (state != ST_SLEEP);
    assign main_regulator_en = (state != ST_SLEEP);
    assign system_clock_mux_sel = clock_mux(system_clock_source[CLKSRC_LSB+:2]);

    // watchdog on the cpu clock
    wire wdog_expire = cpu_clock_en && wdog_en && (wdog_count == WDOG_LIMIT);
    wire wdog_restart = wr_wdog && pwdata[WD_RESTART_BIT];
    wire wdog_flag_clr = wr_wdog && pwdata[WD_FLAG_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_en <= 1'b0;
            wdog_rstmode <= 1'b0;
            wdog_count <= 30'h0;
            wdog_flag <= 1'b0;
            wdog_reset <= 1'b0;
        end else begin
            if (wr_wdog) begin
                wdog_en <= pwdata[WD_EN_BIT];
                wdog_rstmode <= pwdata[WD_RSTMODE_BIT];
            end
            if (wdog_restart || wdog_expire) begin
                wdog_count <= 30'h0;
            end else if (cpu_clock_en && wdog_en) begin
                wdog_count <= wdog_count + 30'h1;
            end
            if (wdog_expire && !wdog_rstmode) begin
                wdog_flag <= 1'b1;
            end else if (wdog_flag_clr) begin
                wdog_flag <= 1'b0;
            end
            wdog_reset <= wdog_expire && wdog_rstmode;
        end
    end

    assign wdog_irq = wdog_flag;

    // checks
    sequence s_entry_done;
        (state == ST_STOP_ENTRY) && fast_last_edge;
    endsequence

    property p_mask_reset;
        @(posedge pclk) $rose(presetn) |-> (wake_mask == RST_WAKE_MASK);
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask not all ones at reset");

    property p_edge_only;
        @(posedge pclk) disable iff (!presetn)
            (state == ST_STOP) && (wake_latch == '0) && $stable(wake_s2)
            |=> (state == ST_STOP);
    endproperty
    a_edge_only: assert property (p_edge_only) else $error("stop left without an edge");

    property p_stop_wake;
        @(posedge pclk) disable iff (!presetn)
            (state == ST_STOP) && wake_any |=> (state == ST_RUN) && osc_enable && wake_resume
            && !power_ctrl[PWR_STOP_BIT];
    endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("stop wake did not resume");

    property p_masked_line;
        @(posedge pclk) disable iff (!presetn)
            clock_parked && (wake_latch == '0) && (wake_rise & wake_allow) == '0
            |=> (wake_latch == '0);
    endproperty
    a_masked_line: assert property (p_masked_line) else $error("masked line latched");

    property p_retry_stop;
        @(posedge pclk) disable iff (!presetn)
            (state == ST_STOP) && ((ext_woken & irq_enable) != '0) |=> resume_retry;
    endproperty
    a_retry_stop: assert property (p_retry_stop) else $error("stop service not retried");

    property p_idle_gating;
        @(posedge pclk) disable iff (!presetn)
            (state == ST_IDLE) |-> !cpu_clock_en && periph_clock_en && integrated_block;
    endproperty
    a_idle_gating: assert property (p_idle_gating) else $error("idle gating wrong");

    property p_idle_exit;
        @(posedge pclk) disable iff (!presetn)
            (state == ST_IDLE) && idle_exit |=> (state == ST_RUN) && wake_resume
            && !power_ctrl[PWR_IDLE_BIT] && (wake_vector != '0);
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("idle exit incomplete");

    property p_osc_stop;
        @(posedge pclk) disable iff (!presetn)
            s_entry_done |=> !osc_enable && !cpu_clock_en;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("oscillator not stopped on edge");

    property p_entry_wait;
        @(posedge pclk) disable iff (!presetn)
            (state == ST_RUN) && !cpu_instr_done |=> (state == ST_RUN);
    endproperty
    a_entry_wait: assert property (p_entry_wait) else $error("mode entered mid instruction");

    property p_sleep_regulator;
        @(posedge pclk) disable iff (!presetn)
            (state == ST_SLEEP) && wake_any |-> !main_regulator_en ##1
            (main_regulator_en && !cpu_clock_en);
    endproperty
    a_sleep_regulator: assert property (p_sleep_regulator) else $error("sleep regulator wrong");

    property p_settle_count;
        @(posedge pclk) disable iff (!presetn)
            (state == ST_SETTLE) && slow_tick && (settle_count != settle_limit - 9'h001)
            |=> (state == ST_SETTLE);
    endproperty
    a_settle_count: assert property (p_settle_count) else $error("settle ended early");

    property p_wdog_halt;
        @(posedge pclk) disable iff (!presetn)
            !cpu_clock_en && !wdog_restart |=> $stable(wdog_count);
    endproperty
    a_wdog_halt: assert property (p_wdog_halt) else $error("watchdog ran without cpu clock");

endmodule : power_mode_wakeup_control

// ==== testbench/wake_partner.sv ====
`timescale 1ns/10ps
// oscillators and cpu core stand-in
module wake_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cpu_clock_en,
    input wire logic osc_enable,
    output logic slow_osc,
    output logic fast_internal_osc,
    output logic cpu_instr_done
);
    logic [1:0] cnt;
    initial begin
        slow_osc = 1'b0;
        fast_internal_osc = 1'b0;
    end
    // slow oscillator never stops
    always #20 slow_osc = ~slow_osc;
    // fast oscillator stands low once disabled
    always begin
        #7;
        fast_internal_osc <= osc_enable ? ~fast_internal_osc : 1'b0;
    end
    // an instruction completes every fourth cycle while clocked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 2'h0;
            cpu_instr_done <= 1'b0;
        end else begin
            cnt <= cnt + 2'h1;
            cpu_instr_done <= cpu_clock_en && (cnt == 2'h3);
        end
    end
endmodule : wake_partner

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    import power_mode_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, slow_osc, fast_osc, done, cpu_en, per_en, blk, osc_en, reg_en;
    logic [7:0] pins = 8'h00, irq = 8'h00, irq_en = 8'h00, vec;
    logic tk = 1'b0, lin = 1'b0, st = 1'b0, resume, retry, wirq, wrst, ps;
    logic [1:0] mux;
    int err_count = 0, n_compared = 0, j, k, n, e;
    int mask_m;
    always #5 pclk = ~pclk;
    power_mode_wakeup_control #(.WDOG_LIMIT(30'h14)) power_mode_wakeup_control_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_wake_pins(pins), .touch_key_unit_wake(tk), .lin_wake(lin), .slow_timer_wake(st),
        .slow_osc(slow_osc), .fast_internal_osc(fast_osc), .irq_lines(irq),
        .irq_enable(irq_en), .cpu_instr_done(done), .cpu_clock_en(cpu_en),
        .periph_clock_en(per_en), .integrated_block(blk), .osc_enable(osc_en),
        .main_regulator_en(reg_en), .system_clock_mux_sel(mux), .wake_resume(resume),
        .wake_vector(vec), .resume_retry(retry), .wdog_irq(wirq), .wdog_reset(wrst));
    wake_partner wake_partner_inst (.pclk(pclk), .presetn(presetn), .cpu_clock_en(cpu_en),
        .osc_enable(osc_en), .slow_osc(slow_osc), .fast_internal_osc(fast_osc),
        .cpu_instr_done(done));
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            chk("pready", 0, 1);
            complete_run();
        end
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wait_hi(ref logic s, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge pclk);
            if (s === 1'b1) break;
        end
        if (i == lim) begin
            chk("wait bound", 0, 1);
            complete_run();
        end
    endtask : wait_hi
    task enter(input logic [31:0] bits);
        apb(1'b1, ADDR_POWER_CONTROL, bits);
        repeat (20) @(posedge pclk);
        chk("cpu clock parked", cpu_en, 0);
    endtask : enter
    initial begin
        void'($urandom(74196));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk("cpu clock in reset", cpu_en, 0);
        wait_hi(cpu_en, 2000);
        apb(1'b0, ADDR_WAKE_MASK, 0);
        chk("mask reset", rd, 32'hFF);
        apb(1'b0, ADDR_SYSTEM_CLOCK_SOURCE, 0);
        chk("source reset", rd, 32'h0C);
        apb(1'b0, 12'hFFC, 0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, ADDR_SYSTEM_CLOCK_SOURCE, c);
            @(negedge pclk);
            chk("mux", mux, (c == 3) ? 2 : (c == 1) ? 1 : 0);
        end
        apb(1'b1, ADDR_SYSTEM_CLOCK_SOURCE, 32'h0);
        j = $urandom_range(7, 0);
        k = (j + 1 + $urandom_range(6, 0)) % 8;
        mask_m = ($urandom & ~(1 << k)) | (1 << j);
        apb(1'b1, ADDR_WAKE_MASK, mask_m);
        irq_en <= 8'(1 << j);
        // idle then wake by enabled line
        apb(1'b1, ADDR_POWER_CONTROL, 32'h1);
        irq <= 8'(~(1 << j));
        repeat (10) @(posedge pclk);
        chk("idle clocks", {cpu_en, per_en, blk}, 3'b011);
        apb(1'b0, ADDR_POWER_STATUS, 0);
        chk("status idle", rd, 32'h4);
        chk("disabled lines keep idle", cpu_en, 0);
        irq <= 8'(1 << j);
        wait_hi(resume, 20);
        chk("idle vector", {retry, vec}, 9'(1 << j));
        irq <= 8'h00;
        apb(1'b0, ADDR_POWER_CONTROL, 0);
        chk("idle bit cleared", rd, 0);
        // stop: masked line refused, unmasked enabled line wakes
        enter(32'h2);
        chk("osc off", osc_en, 0);
        pins[k] <= 1'b1;
        repeat (15) @(posedge pclk);
        chk("masked line ignored", cpu_en, 0);
        pins <= 8'(1 << j);
        wait_hi(resume, 20);
        chk("stop vector", {retry, vec}, {1'b1, 8'(1 << j)});
        chk("osc back", {osc_en, mux}, 3'b100);
        pins[j] <= 1'b0;
        apb(1'b0, ADDR_POWER_CONTROL, 0);
        chk("stop bit cleared", rd, 0);
        // clockless source wakes with no interrupt enabled
        irq_en <= 8'h00;
        tk <= 1'b1;
        repeat (4) @(posedge pclk);
        enter(32'h2);
        chk("level does not wake", {cpu_en, osc_en}, 0);
        lin <= 1'b1;
        wait_hi(resume, 20);
        chk("no vector", {retry, vec}, 0);
        lin <= 1'b0;
        tk <= 1'b0;
        // sleep with every settle code
        for (int c = 0; c < 4; c++) begin
            n = (c == 0) ? 8 : (c == 1) ? 16 : (c == 2) ? 64 : 256;
            apb(1'b1, ADDR_SYSTEM_CLOCK_SOURCE, c << 2);
            enter(32'h4);
            chk("regulator off", reg_en, 0);
            pins[j] <= 1'b1;
            e = 0;
            ps = slow_osc;
            wait_hi(reg_en, 20);
            for (int i = 0; i < 3000 && cpu_en !== 1'b1; i++) begin
                @(posedge pclk);
                if (slow_osc && !ps) e++;
                ps = slow_osc;
            end
            if (cpu_en !== 1'b1) begin
                chk("settle bound", 0, 1);
                complete_run();
            end
            chk("settle slow edges", (e >= n - 1) && (e <= n + 3), 1);
            pins[j] <= 1'b0;
        end
        // watchdog interrupt flag, flag clear and reset pulse
        apb(1'b1, ADDR_WDOG_CTRL, 32'h1);
        repeat (30) @(posedge pclk);
        chk("watchdog flag", wirq, 1);
        apb(1'b1, ADDR_WDOG_CTRL, 32'h8);
        repeat (2) @(posedge pclk);
        chk("watchdog cleared", wirq, 0);
        apb(1'b1, ADDR_WDOG_CTRL, 32'h3);
        wait_hi(wrst, 40);
        chk("watchdog reset pulse", {wrst, wirq}, 2'b10);
        apb(1'b1, ADDR_WDOG_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        chk("watchdog reset pulse ends", wrst, 0);
        complete_run();
    end
endmodule : tb_top
